// ### speed_ref_pkg.sv
/*
 * Shared definitions for the speed reference scaling block: encodings,
 * fixed-point scales, limits, reset values and the configuration carrier.
 * Assumes percentages in tenths (1000 = 100.0 %) and a 12-bit ADC sample
 * of the first analog input where full code is 10 V or 20 mA.
 */
`default_nettype none

package speed_ref_pkg;

	localparam int unsigned AIN_BITS = 12;
	localparam int unsigned SPD_BITS = 16;

	// Control source values that enable follower scaling
	localparam logic [3:0] SRC_KEYPAD_FWD  = 4'h1;
	localparam logic [3:0] SRC_KEYPAD_BIDI = 4'h2;
	localparam logic [3:0] SRC_FOLLOWER    = 4'h3;

	typedef enum logic [1:0] {
		SCALE_OFF    = 2'b00,
		SCALE_FACTOR = 2'b01,
		SCALE_OFFSET = 2'b10,
		SCALE_TRIM   = 2'b11
	} scaling_mode_t;

	typedef enum logic [2:0] {
		FMT_V_0_10       = 3'b000,
		FMT_V_10_0       = 3'b001,
		FMT_V_BIPOLAR    = 3'b010,
		FMT_MA_0_20      = 3'b011,
		FMT_MA_4_20_TRIP = 3'b100,
		FMT_MA_4_20_RAMP = 3'b101,
		FMT_MA_20_4_TRIP = 3'b110,
		FMT_MA_20_4_RAMP = 3'b111
	} ain_format_t;

	// Fixed-point scales, in tenths of a percent
	localparam int PCT_FULL        = 1000;
	localparam int FACTOR_MIN      = -5000;
	localparam int FACTOR_MAX      = 5000;
	localparam int GAIN_MAX        = 20000;
	localparam logic signed [15:0] FACTOR_DEFAULT = 16'sh03e8;
	localparam logic [15:0]        GAIN_DEFAULT   = 16'h03e8;

	// ADC codes and current-loop figures
	localparam int AIN_FULL_CODE = 4095;
	localparam int AIN_MID_CODE  = 2048;
	localparam int LOOP_FULL_MA  = 20;
	localparam int LOOP_ZERO_MA  = 4;
	localparam int LOOP_LOSS_MA  = 3;
	localparam int AIN_4MA_CODE  = (AIN_FULL_CODE * LOOP_ZERO_MA) / LOOP_FULL_MA;

	localparam int SPD_MAX = 32767;
	localparam int SPD_MIN = -32768;

	typedef struct packed {
		logic [3:0]          control_source_select;
		scaling_mode_t       follower_scaling_mode;
		logic signed [15:0]  follower_scaling_factor;
		ain_format_t         input1_signal_format;
		logic [15:0]         input1_gain;
	} scaling_cfg_t;

	localparam scaling_cfg_t CFG_RESET = '{
		control_source_select:   4'h0,
		follower_scaling_mode:   SCALE_OFF,
		follower_scaling_factor: FACTOR_DEFAULT,
		input1_signal_format:    FMT_V_0_10,
		input1_gain:             GAIN_DEFAULT
	};

	function automatic logic is_loop_4_20(input ain_format_t f);
		return f inside {FMT_MA_4_20_TRIP, FMT_MA_4_20_RAMP,
			FMT_MA_20_4_TRIP, FMT_MA_20_4_RAMP};
	endfunction

	function automatic logic is_trip_format(input ain_format_t f);
		return (f == FMT_MA_4_20_TRIP) || (f == FMT_MA_20_4_TRIP);
	endfunction

	function automatic logic is_ramp_format(input ain_format_t f);
		return (f == FMT_MA_4_20_RAMP) || (f == FMT_MA_20_4_RAMP);
	endfunction

endpackage

`default_nettype wire

// ### ain1_conditioner.sv
/*
 * First analog input conditioner: turns the raw ADC code into a signed
 * level in tenths of a percent per the selected signal format, applies
 * the input gain and flags current-loop loss. One register stage.
 * Assumes the sample is synchronous to i_clk and held valid every cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module ain1_conditioner
	import speed_ref_pkg::*;
(
	// Clock and reset
	input  wire logic                i_clk,
	input  wire logic                i_rst_n,
	// Input and setup
	input  wire logic [AIN_BITS-1:0] i_sample,
	input  wire ain_format_t         i_format,
	input  wire logic [15:0]         i_gain,
	// Conditioned result
	output var  logic signed [15:0]  o_level,
	output var  logic                o_loss
);

	logic signed [31:0] code;
	logic signed [31:0] base;
	logic signed [31:0] gained;
	logic signed [31:0] gain_lim;
	logic               loss_next;

	function automatic logic signed [31:0] span_pct(input logic signed [31:0] num,
		input logic signed [31:0] den);
		return (num * PCT_FULL) / den;
	endfunction

	function automatic logic signed [31:0] loop_pct(input logic signed [31:0] c);
		logic signed [31:0] above;
		above = c - AIN_4MA_CODE;
		if (above < 0)
			above = 0;
		return span_pct(above, AIN_FULL_CODE - AIN_4MA_CODE);
	endfunction

	assign code = {{(32-AIN_BITS){1'b0}}, i_sample};

	always_comb
	begin
		case (i_format)
			FMT_V_0_10:       base = span_pct(code, AIN_FULL_CODE);
			FMT_V_10_0:       base = PCT_FULL - span_pct(code, AIN_FULL_CODE);
			FMT_V_BIPOLAR:    base = span_pct(code - AIN_MID_CODE, AIN_MID_CODE);
			FMT_MA_0_20:      base = span_pct(code, AIN_FULL_CODE);
			FMT_MA_4_20_TRIP,
			FMT_MA_4_20_RAMP: base = loop_pct(code);
			FMT_MA_20_4_TRIP,
			FMT_MA_20_4_RAMP: base = PCT_FULL - loop_pct(code);
			default:          base = 0;
		endcase
	end

	// Gain beyond the allowed span is clamped rather than wrapped
	assign gain_lim = (i_gain > 16'(GAIN_MAX)) ? GAIN_MAX : {16'h0000, i_gain};
	assign gained   = (base * gain_lim) / PCT_FULL;

	// Compare currents without dividing so 3 mA is exact
	assign loss_next = is_loop_4_20(i_format)
		&& (code * LOOP_FULL_MA < LOOP_LOSS_MA * AIN_FULL_CODE);

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_level <= 16'sh0000;
		else
			o_level <= gained[15:0];
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_loss <= 1'b0;
		else
			o_loss <= loss_next;
	end

endmodule

`default_nettype wire

// ### speed_reference_scaling.sv
/*
 * Speed reference conditioning: scales the master speed by the follower
 * factor, optionally combines it with the first analog input as offset or
 * trim, and handles current-loop loss by trip or preset-speed fallback.
 * Assumes all inputs are synchronous to i_clk; ramping toward the chosen
 * reference and stopping on a trip happen in the drive logic downstream.
 */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Scale only in keypad or follower source
// - Mode 0 passes, mode 1 multiplies by factor
// - Mode 2 adds analog input as offset
// - Mode 3 multiplies by analog input trim
// - Unipolar volts direct or inverted mapping
// - 0-20 mA linear, no loss detection
// - 4-20 trip format faults below 3 mA
// - 4-20 ramp format selects preset eight
// - Inverted 20-4 formats, same loss handling
module speed_reference_scaling
	import speed_ref_pkg::*;
(
	// Clock and reset
	input  wire logic                       i_clk,
	input  wire logic                       i_rst_n,
	// Configuration
	input  wire scaling_cfg_t               i_cfg,
	// Speed sources
	input  wire logic signed [SPD_BITS-1:0] i_master_speed,
	input  wire logic [SPD_BITS-1:0]        i_max_speed,
	input  wire logic signed [SPD_BITS-1:0] i_preset_speed_eight,
	// Analog input and fault handling
	input  wire logic [AIN_BITS-1:0]        i_ain1_sample,
	input  wire logic                       i_fault_clear,
	// Results
	output var  logic signed [SPD_BITS-1:0] o_speed_reference,
	output var  logic signed [15:0]         o_ain1_level,
	output var  logic                       o_scaling_active,
	output var  logic                       o_preset_eight_select,
	output var  logic                       o_current_loop_loss_fault
);

	scaling_cfg_t                cfg_reg;
	logic signed [SPD_BITS-1:0]  master_reg;
	logic [SPD_BITS-1:0]         max_reg;
	logic signed [SPD_BITS-1:0]  preset_reg;

	logic signed [15:0]          ain_level;
	logic                        ain_loss;

	logic signed [47:0]          factor_lim;
	logic signed [47:0]          scaled;
	logic signed [47:0]          combined;
	logic signed [47:0]          offset_spd;
	logic                        src_allows;
	logic                        ramp_loss;
	logic                        trip_loss;
	logic signed [SPD_BITS-1:0]  reference_next;
	logic                        fault_next;
	logic                        scaling_active_next;
	logic                        preset_select_next;

	// Saturate rather than wrap so a large product cannot reverse direction
	function automatic logic signed [SPD_BITS-1:0] sat_speed(input logic signed [47:0] v);
		if (v > SPD_MAX)
			return SPD_BITS'(SPD_MAX);
		else if (v < SPD_MIN)
			return SPD_BITS'(SPD_MIN);
		else
			return v[SPD_BITS-1:0];
	endfunction

	function automatic logic signed [47:0] pct_mul(input logic signed [47:0] a,
		input logic signed [47:0] pct);
		return (a * pct) / PCT_FULL;
	endfunction

	function automatic logic source_enables(input logic [3:0] src);
		return (src == SRC_KEYPAD_FWD)
			|| (src == SRC_KEYPAD_BIDI)
			|| (src == SRC_FOLLOWER);
	endfunction

	// Analog path adds a register stage, so the rest is aligned to it
	ain1_conditioner u_ain1 (
		.i_clk            (i_clk),
		.i_rst_n          (i_rst_n),
		.i_sample         (i_ain1_sample),
		.i_format         (i_cfg.input1_signal_format),
		.i_gain           (i_cfg.input1_gain),
		.o_level          (ain_level),
		.o_loss           (ain_loss)
	);

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			cfg_reg <= CFG_RESET;
		else
			cfg_reg <= i_cfg;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			master_reg <= '0;
		else
			master_reg <= i_master_speed;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			max_reg <= '0;
		else
			max_reg <= i_max_speed;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			preset_reg <= '0;
		else
			preset_reg <= i_preset_speed_eight;
	end

	assign src_allows = source_enables(cfg_reg.control_source_select);

	// Out-of-range factor is clamped so a bad setting cannot overflow
	always_comb
	begin
		factor_lim = 48'(cfg_reg.follower_scaling_factor);
		if (factor_lim > FACTOR_MAX)
			factor_lim = 48'(FACTOR_MAX);
		else if (factor_lim < FACTOR_MIN)
			factor_lim = 48'(FACTOR_MIN);
	end

	assign scaled     = pct_mul(48'(master_reg), factor_lim);
	// Offset is a percentage of maximum speed
	assign offset_spd = pct_mul(48'({1'b0, max_reg}), 48'(ain_level));

	always_comb
	begin
		case (cfg_reg.follower_scaling_mode)
			SCALE_OFF:    combined = 48'(master_reg);
			SCALE_FACTOR: combined = scaled;
			SCALE_OFFSET: combined = scaled + offset_spd;
			SCALE_TRIM:   combined = pct_mul(scaled, 48'(ain_level));
			default:      combined = 48'(master_reg);
		endcase
	end

	assign ramp_loss = ain_loss && is_ramp_format(cfg_reg.input1_signal_format);
	assign trip_loss = ain_loss && is_trip_format(cfg_reg.input1_signal_format);

	// Hardware set wins over a clear in the same cycle
	assign fault_next = trip_loss || (o_current_loop_loss_fault && !i_fault_clear);

	// Ramping toward the preset is left to the drive; only the target moves here
	assign preset_select_next  = ramp_loss && !fault_next;
	assign scaling_active_next = src_allows
		&& (cfg_reg.follower_scaling_mode != SCALE_OFF);

	always_comb
	begin
		// A trip holds zero; bringing the motor to rest is done downstream
		if (fault_next)
			reference_next = '0;
		else if (ramp_loss)
			reference_next = preset_reg;
		else if (src_allows)
			reference_next = sat_speed(combined);
		else
			reference_next = master_reg;
	end

	// Clear is taken unregistered, so it acts on the edge that samples it
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_current_loop_loss_fault <= 1'b0;
		else
			o_current_loop_loss_fault <= fault_next;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_speed_reference <= '0;
		else
			o_speed_reference <= reference_next;
	end

	// Level is delayed once more so it lines up with the reference
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_ain1_level <= '0;
		else
			o_ain1_level <= ain_level;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_scaling_active <= 1'b0;
		else
			o_scaling_active <= scaling_active_next;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_preset_eight_select <= 1'b0;
		else
			o_preset_eight_select <= preset_select_next;
	end

endmodule

`default_nettype wire

// ### speed_reference_scaling_assertions.sv
/* Checker for the speed reference scaling ports.
 * Assumes outputs show the inputs of two rising edges earlier. */
`timescale 1ns/1ps
`default_nettype none
module speed_reference_scaling_assertions
	import speed_ref_pkg::*;
(
	// Inputs watched
	input wire logic                i_clk,
	input wire logic                i_rst_n,
	input wire scaling_cfg_t        i_cfg,
	input wire logic signed [15:0]  i_master_speed,
	input wire logic signed [15:0]  i_preset_speed_eight,
	input wire logic [AIN_BITS-1:0] i_ain1_sample,
	// Outputs watched
	input wire logic signed [15:0]  o_speed_reference,
	input wire logic signed [15:0]  o_ain1_level,
	input wire logic                o_scaling_active,
	input wire logic                o_preset_eight_select,
	input wire logic                o_current_loop_loss_fault
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	logic        src_on;
	logic        low;
	ain_format_t fmt;
	assign src_on = i_cfg.control_source_select inside {4'h1, 4'h2, 4'h3};
	assign low = i_ain1_sample <= 12'h266;
	assign fmt = i_cfg.input1_signal_format;
	AST_SRC_OFF: assert property (!src_on |-> ##2 !o_scaling_active)
		else $error("scaling active outside keypad or follower source");
	AST_SRC_ON: assert property (src_on && i_cfg.follower_scaling_mode != SCALE_OFF
		|-> ##2 o_scaling_active) else $error("scaling not active");
	AST_PASS: assert property ((!src_on || i_cfg.follower_scaling_mode == SCALE_OFF)
		&& fmt < FMT_MA_4_20_TRIP ##2 !o_current_loop_loss_fault
		|-> o_speed_reference == $past(i_master_speed, 2)) else $error("master not passed");
	AST_TRIP: assert property (fmt inside {FMT_MA_4_20_TRIP, FMT_MA_20_4_TRIP} && low
		|-> ##2 o_current_loop_loss_fault) else $error("loop loss did not trip");
	AST_RAMP: assert property (fmt inside {FMT_MA_4_20_RAMP, FMT_MA_20_4_RAMP} && low
		|-> ##2 (o_preset_eight_select || o_current_loop_loss_fault))
		else $error("loop loss did not select preset");
	AST_PRESET_REF: assert property (o_preset_eight_select && !o_current_loop_loss_fault
		|-> o_speed_reference == $past(i_preset_speed_eight, 2)) else $error("preset not used");
	AST_NO_LOSS: assert property (fmt < FMT_MA_4_20_TRIP || !low
		|-> ##2 !o_preset_eight_select) else $error("preset selected without loss");
	AST_FAULT_ZERO: assert property (o_current_loop_loss_fault
		|-> o_speed_reference == 16'sh0000) else $error("reference not zero on fault");
	AST_V010: assert property (fmt == FMT_V_0_10 && i_cfg.input1_gain == 16'h03e8
		|-> ##2 o_ain1_level == 16'(int'($past(i_ain1_sample, 2)) * 1000 / 4095))
		else $error("voltage level wrong");
endmodule
bind speed_reference_scaling speed_reference_scaling_assertions chk (.i_clk, .i_rst_n,
	.i_cfg, .i_master_speed, .i_preset_speed_eight, .i_ain1_sample, .o_speed_reference,
	.o_ain1_level, .o_scaling_active, .o_preset_eight_select, .o_current_loop_loss_fault);
`default_nettype wire

// ### speed_source_model.sv
/* Master speed source and analog transmitter model.
 * Assumes commands change on the falling edge; it follows one cycle later. */
`timescale 1ns/1ps
`default_nettype none
module speed_source_model (
	input  wire logic               i_clk,
	input  wire logic [11:0]        i_code,
	input  wire logic signed [15:0] i_speed,
	output var  logic [11:0]        o_sample,
	output var  logic signed [15:0] o_master_speed
);
	// Changes land on the falling edge, away from the sampling edge
	always_ff @(negedge i_clk)
	begin
		o_sample <= i_code;
		o_master_speed <= i_speed;
	end
endmodule
`default_nettype wire

// ### speed_reference_scaling_bench.sv
/* Self-checking bench for the speed reference scaling block.
 * Assumes a 40 MHz clock and inputs held long enough to settle. */
`timescale 1ns/1ps
`default_nettype none
module speed_reference_scaling_bench;
	import speed_ref_pkg::*;
	logic               clk, rst_n, clr, act, psel, flt;
	scaling_cfg_t       cfg;
	logic [11:0]        code, sample;
	logic signed [15:0] spd, master, maxs, preset, sref, lvl;
	logic [31:0]        seed = 32'd53;
	int                 n_errors, tests_run;
	int                 el, er;
	speed_source_model src (.i_clk(clk), .i_code(code), .i_speed(spd), .o_sample(sample),
		.o_master_speed(master));
	speed_reference_scaling uut (.i_clk(clk), .i_rst_n(rst_n), .i_cfg(cfg),
		.i_master_speed(master), .i_max_speed(maxs), .i_preset_speed_eight(preset),
		.i_ain1_sample(sample), .i_fault_clear(clr), .o_speed_reference(sref),
		.o_ain1_level(lvl), .o_scaling_active(act), .o_preset_eight_select(psel),
		.o_current_loop_loss_fault(flt));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int exp_level(int f, int c, int g);
		int b;
		int d;
		d = c > 819 ? (c - 819) * 1000 / 3276 : 0;
		case (f)
			1: b = 1000 - c * 1000 / 4095;
			2: b = (c - 2048) * 1000 / 2048;
			4, 5: b = d;
			6, 7: b = 1000 - d;
			default: b = c * 1000 / 4095;
		endcase
		return b * (g > 20000 ? 20000 : g) / 1000;
	endfunction
	function automatic int exp_ref(int s, int md, int m, int fr, int mx, int l);
		int f;
		longint r;
		f = fr > 5000 ? 5000 : (fr < -5000 ? -5000 : fr);
		r = m;
		if (s >= 1 && s <= 3)
			case (md)
				1: r = m * f / 1000;
				2: r = m * f / 1000 + mx * l / 1000;
				3: r = longint'(m * f / 1000) * l / 1000;
				default: r = m;
			endcase
		return int'(r > 32767 ? 32767 : (r < -32768 ? -32768 : r));
	endfunction
	task automatic check(logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	initial
	begin
		#200000;
		n_errors++;
		give_verdict();
	end
	initial
	begin
		rst_n = 0;
		clr = 0;
		cfg = CFG_RESET;
		code = 0;
		spd = 0;
		maxs = 16'h0fa0;
		preset = 16'sh0123;
		repeat (5) @(negedge clk);
		rst_n <= 1;
		for (int i = 0; i < 300; i++)
		begin
			cfg.control_source_select <= 4'(rnd() % 5);
			cfg.follower_scaling_mode <= scaling_mode_t'(rnd() % 4);
			// First two steps push the factor past both clamp limits
			cfg.follower_scaling_factor <= (i < 2) ? (i ? -16'sd6000 : 16'sd6000)
				: 16'(int'(rnd() % 12001) - 6000);
			// First steps use 0-10 V at unity gain as a known level
			cfg.input1_signal_format <= ain_format_t'((i < 4) ? 0 : rnd() % 4);
			cfg.input1_gain <= (i < 4) ? 16'h03e8 : 16'(rnd() % 22000);
			code <= 12'(rnd());
			spd <= 16'(rnd());
			maxs <= 16'(rnd() % 8000);
			repeat (4) @(negedge clk);
			el = exp_level(int'(cfg.input1_signal_format), int'(code), int'(cfg.input1_gain));
			er = exp_ref(int'(cfg.control_source_select), int'(cfg.follower_scaling_mode),
				int'(spd), int'($signed(cfg.follower_scaling_factor)), int'(maxs), el);
			check(32'(lvl), el);
			check(32'(sref), er);
			check(act, (cfg.control_source_select inside {4'h1, 4'h2, 4'h3})
				&& (cfg.follower_scaling_mode != SCALE_OFF));
		end
		cfg <= CFG_RESET;
		@(negedge clk);
		for (int f = 3; f < 8; f++)
		begin
			cfg.input1_signal_format <= ain_format_t'(f);
			code <= 12'h266;
			preset <= 16'(rnd());
			repeat (4) @(negedge clk);
			check(flt, f == 4 || f == 6);
			check(psel, f == 5 || f == 7);
			check(32'(sref), (f == 5 || f == 7) ? 32'(preset) : (f == 3 ? 32'(spd) : 0));
			clr <= 1;
			repeat (2) @(negedge clk);
			check(flt, f == 4 || f == 6);
			code <= 12'h267;
			repeat (4) @(negedge clk);
			check(flt, 0);
			check(psel, 0);
			check(32'(lvl), exp_level(f, 'h267, 1000));
			clr <= 0;
		end
		give_verdict();
	end
endmodule
`default_nettype wire
